/* hw/nbch_cfg.svh */
// Field offsets, codes and limits of the boot command handler.
`ifndef NBCH_CFG_SVH
`define NBCH_CFG_SVH
`define NBCH_OFF_ID 9'h002
`define NBCH_OFF_REQ 9'h012
`define NBCH_OFF_RC 9'h013
`define NBCH_OFF_MLEN 9'h014
`define NBCH_OFF_BODY 9'h016
`define NBCH_OFF_RESV 9'h018
`define NBCH_OFF_DATA 9'h020
`define NBCH_OFF_CFG_END 9'h066
`define NBCH_LEN_EX 9'h01a
`define NBCH_ID_W 128
`define NBCH_SESS_W 96
`define NBCH_CODE_WR 8'h00
`define NBCH_CODE_RD 8'h01
`define NBCH_CODE_EX 8'h02
`define NBCH_CODE_CF 8'h03
`define NBCH_ST_OK 8'h00
`define NBCH_ST_INV 8'ha1
`define NBCH_ST_BADPC 8'ha2
`define NBCH_ST_NOMEM 8'ha3
`define NBCH_MLEN_RW 16'h000a
`define NBCH_MLEN_CF 16'h0050
`define NBCH_MLEN_EX 16'h0004
`define NBCH_MAX_DATA 16'h01ce
`define NBCH_CFG_LEN 80
`define NBCH_CFG_COMP 2
`define NBCH_CFG_MODE 3
`define NBCH_CFG_HOSTS 4
`define NBCH_CFG_HOSTQ 5
`define NBCH_MODE_NET 8'h02
`define NBCH_IDX_MAX 9'h1ff
`endif

/* hw/nbch_pkg.sv */
// Types shared by the boot command handler.
package nbch_pkg;
  typedef enum logic [2:0] {
    NBCH_RX = 3'b000,
    NBCH_PROC = 3'b001,
    NBCH_LOAD = 3'b010,
    NBCH_FETCH = 3'b011,
    NBCH_SEND = 3'b100
  } nbch_state_t;
  typedef logic [7:0] nbch_byte_t;
endpackage

/* hw/nbch_ram.sv */
// Byte-wide user memory with a registered read port.
`timescale 1ns/1ps
module nbch_ram import nbch_pkg::*; #(
  parameter int AW = 12
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Write port.
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire nbch_byte_t wdata,
  // Read port.
  input wire logic [AW-1:0] raddr,
  output nbch_byte_t rdata
);
  nbch_byte_t mem [2**AW];

  // The array has no reset, so user memory is undefined until written.
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read data always come out of a register, one cycle after the address.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

/* hw/nbch_top.sv */
// Command phase of the network bootstrap: parses requests, acts, replies.
// How it works
// - Write request: length at 22, reserved at 24, address at 28, data from 32.
// - Write reply length reports bytes actually copied into memory.
// - Reserved field is zero in requests; reply value is don't-care.
// - Address is segment plus offset and is echoed unchanged.
// - Write reply carries no data field.
// - Read request uses code 1, echoed in reply.
// - Read status: 0 ok, A3H missing memory, A1H invalid.
// - Read request message length is 10; reply length follows data size.
// - Read length is the fetch count; reply reports bytes fetched.
// - Read reply carries fetched data, at most 462 bytes.
// - First 12 identifier bytes hold the session; whole identifier is echoed.
// - Configure request uses code 3, echoed in reply.
// - Configure reply code equals the block's completion code.
// - Configure message length is 80 both ways; block at offset 22.
// - Host count zero leaves host queue fields untouched.
// - Operation mode must be 2 and reply always shows 2.
// - Configuration persists without a request; reset defaults otherwise.
// - Execute request uses code 2, echoed in reply.
// - Execute status: 0 ok, A1H invalid, A2H bad start address.
// - Execute length 4; start address at 22 loads the PC, echoed.
// - After execute, every later bootstrap packet is discarded.
// - Write request uses code 0, echoed in reply.
// - Write status: 0 ok, A3H overlaps reserved memory, A1H invalid.
// - Requests are accepted only when the session matches.
`timescale 1ns/1ps
`include "nbch_cfg.svh"
module nbch_top import nbch_pkg::*; #(
  parameter int RAM_AW = 12,
  parameter int RAM_BYTES = 4096,
  parameter int RESV_TOP = 256
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Session from the discovery exchange.
  input wire logic sess_valid,
  input wire logic [`NBCH_SESS_W-1:0] sess_id,
  // Request byte stream.
  input wire logic rx_valid,
  input wire nbch_byte_t rx_data,
  input wire logic rx_last,
  output logic rx_ready,
  // Reply byte stream.
  output logic tx_valid,
  output nbch_byte_t tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  // Start of the loaded program.
  output logic exec_go,
  output logic [31:0] exec_pc,
  output logic boot_done
);
  nbch_state_t state;
  nbch_state_t next_state;
  logic [8:0] rx_idx;
  logic [8:0] tx_idx;
  logic [15:0] sub_q;
  logic [`NBCH_ID_W-1:0] id_q;
  nbch_byte_t reqc;
  logic [15:0] mlen;
  nbch_byte_t cfg_in [`NBCH_CFG_LEN];
  nbch_byte_t cfg_q [`NBCH_CFG_LEN];
  logic [15:0] wr_cnt;
  nbch_byte_t rsp_st;
  logic [15:0] rsp_cnt;
  logic [8:0] rsp_len;
  nbch_byte_t mem_rdata;

  // Linear address of a segment:offset pair; the sum wraps at one megabyte.
  function automatic logic [19:0] seg_lin(input logic [31:0] a);
    seg_lin = {a[31:16], 4'h0} + {4'h0, a[15:0]};
  endfunction
  // A block is usable when it avoids firmware space and ends inside memory.
  function automatic logic rng_ok(input logic [19:0] lin, input logic [15:0] n);
    rng_ok = (lin >= 20'(RESV_TOP)) && (({1'b0, lin} + {5'h00, n}) <= 21'(RAM_BYTES));
  endfunction
  // Reply byte at a given offset.
  function automatic nbch_byte_t rep_byte(input logic [8:0] i);
    logic [6:0] k;
    logic [3:0] j;
    logic [15:0] ml;
    k = 7'(i - `NBCH_OFF_BODY);
    j = 4'(i - `NBCH_OFF_ID);
    ml = {7'h00, rsp_len - `NBCH_OFF_BODY};
    if (i < `NBCH_OFF_ID) begin
      rep_byte = i[0] ? sub_q[15:8] : sub_q[7:0];
    end else if (i < `NBCH_OFF_REQ) begin
      rep_byte = id_q[(`NBCH_ID_W - 8) - 8 * j +: 8];
    end else if (i == `NBCH_OFF_REQ) begin
      rep_byte = reqc;
    end else if (i == `NBCH_OFF_RC) begin
      rep_byte = rsp_st;
    end else if (i < `NBCH_OFF_BODY) begin
      rep_byte = i[0] ? ml[15:8] : ml[7:0];
    end else if (reqc == `NBCH_CODE_CF) begin
      rep_byte = cfg_q[k];
    end else if (reqc != `NBCH_CODE_EX && i < `NBCH_OFF_RESV) begin
      rep_byte = i[0] ? rsp_cnt[15:8] : rsp_cnt[7:0];
    end else begin
      rep_byte = cfg_in[k];
    end
  endfunction

  // Field views of the captured request body.
  wire rx_take = rx_valid && rx_ready;
  wire in_id = rx_idx >= `NBCH_OFF_ID && rx_idx < `NBCH_OFF_REQ;
  wire in_body = rx_idx >= `NBCH_OFF_BODY && rx_idx < `NBCH_OFF_CFG_END;
  wire in_mlen = rx_idx == `NBCH_OFF_MLEN || rx_idx == `NBCH_OFF_MLEN + 9'h001;
  wire [3:0] id_k = 4'(rx_idx - `NBCH_OFF_ID);
  wire [6:0] body_k = 7'(rx_idx - `NBCH_OFF_BODY);
  wire [15:0] len = {cfg_in[1], cfg_in[0]};
  wire [31:0] rw_addr = {cfg_in[9], cfg_in[8], cfg_in[7], cfg_in[6]};
  wire [31:0] ex_addr = {cfg_in[3], cfg_in[2], cfg_in[1], cfg_in[0]};
  wire [19:0] rw_lin = seg_lin(rw_addr);
  wire len_ok = len <= `NBCH_MAX_DATA;
  wire rw_rng = rng_ok(rw_lin, len);
  wire ex_rng = rng_ok(seg_lin(ex_addr), 16'h0001);
  wire sess_ok = sess_valid && id_q[`NBCH_ID_W-1 -: `NBCH_SESS_W] == sess_id;
  wire drop = boot_done || !sess_ok || rx_idx < `NBCH_OFF_BODY;
  wire mode_ok = cfg_in[`NBCH_CFG_MODE] == `NBCH_MODE_NET;
  wire hosts_none = cfg_in[`NBCH_CFG_HOSTS] == 8'h00;

  // Status of each request kind, computed once the packet has ended.
  wire [7:0] st_wr = !len_ok ? `NBCH_ST_INV : !rw_rng ? `NBCH_ST_NOMEM : `NBCH_ST_OK;
  wire [7:0] st_rd = (!len_ok || mlen != `NBCH_MLEN_RW) ? `NBCH_ST_INV :
                     !rw_rng ? `NBCH_ST_NOMEM : `NBCH_ST_OK;
  wire [7:0] st_cf = (mlen != `NBCH_MLEN_CF || !mode_ok) ? `NBCH_ST_INV : `NBCH_ST_OK;
  wire [7:0] st_ex = mlen != `NBCH_MLEN_EX ? `NBCH_ST_INV :
                     !ex_rng ? `NBCH_ST_BADPC : `NBCH_ST_OK;
  wire is_wr = reqc == `NBCH_CODE_WR;
  wire is_rd = reqc == `NBCH_CODE_RD;
  wire is_ex = reqc == `NBCH_CODE_EX;
  wire is_cf = reqc == `NBCH_CODE_CF;
  wire [7:0] next_st = is_wr ? st_wr : is_rd ? st_rd : is_ex ? st_ex :
                       is_cf ? st_cf : `NBCH_ST_INV;
  wire [15:0] next_cnt = is_wr ? wr_cnt : (is_rd && st_rd == `NBCH_ST_OK) ? len : 16'h0000;
  // Write replies stop at the address field; reads append the data.
  wire [8:0] next_len = is_wr ? `NBCH_OFF_DATA :
                        is_rd ? `NBCH_OFF_DATA + next_cnt[8:0] :
                        is_cf ? `NBCH_OFF_CFG_END :
                        is_ex ? `NBCH_LEN_EX : `NBCH_OFF_BODY;
  wire in_proc = state == NBCH_PROC && !drop;
  wire cf_go = in_proc && is_cf;
  wire ex_go = in_proc && is_ex && st_ex == `NBCH_ST_OK;
  // Data bytes are copied as they arrive; the count stops at the length.
  wire mem_we = rx_take && is_wr && rx_idx >= `NBCH_OFF_DATA && sess_ok && !boot_done &&
                len_ok && rw_rng && wr_cnt < len;
  wire [RAM_AW-1:0] mem_waddr = RAM_AW'(rw_lin + {4'h0, wr_cnt});
  wire [RAM_AW-1:0] mem_raddr = RAM_AW'(rw_lin + {11'h000, tx_idx - `NBCH_OFF_DATA});
  wire fetch_data = is_rd && tx_idx >= `NBCH_OFF_DATA;
  wire last_byte = tx_idx == rsp_len - 9'h001;
  // Next state of the command sequencer.
  always_comb begin
    next_state = state;
    unique case (state)
      NBCH_RX: begin
        if (rx_take && rx_last) begin
          next_state = NBCH_PROC;
        end
      end
      NBCH_PROC: begin
        next_state = drop ? NBCH_RX : NBCH_LOAD;
      end
      NBCH_LOAD: begin
        next_state = fetch_data ? NBCH_FETCH : NBCH_SEND;
      end
      NBCH_FETCH: begin
        next_state = NBCH_SEND;
      end
      NBCH_SEND: begin
        if (tx_ready) begin
          next_state = tx_last ? NBCH_RX : NBCH_LOAD;
        end
      end
      default: begin
        next_state = NBCH_RX;
      end
    endcase
  end

  assign rx_ready = state == NBCH_RX;
  assign tx_valid = state == NBCH_SEND;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= NBCH_RX;
    end else begin
      state <= next_state;
    end
  end

  // Receive index saturates so an oversized packet cannot wrap onto the header.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_idx <= 9'h000;
    end else if (state == NBCH_PROC) begin
      rx_idx <= 9'h000;
    end else if (rx_take && rx_idx != `NBCH_IDX_MAX) begin
      rx_idx <= rx_idx + 9'h001;
    end
  end

  // Header and body capture; the identifier is kept whole for the echo.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sub_q <= 16'h0000;
      id_q <= '0;
      reqc <= 8'h00;
      mlen <= 16'h0000;
      for (int i = 0; i < `NBCH_CFG_LEN; i++) begin
        cfg_in[i] <= 8'h00;
      end
    end else if (rx_take) begin
      if (rx_idx < `NBCH_OFF_ID) begin
        sub_q[8 * rx_idx[0] +: 8] <= rx_data;
      end
      if (in_id) begin
        id_q[(`NBCH_ID_W - 8) - 8 * id_k +: 8] <= rx_data;
      end
      if (rx_idx == `NBCH_OFF_REQ) begin
        reqc <= rx_data;
      end
      if (in_mlen) begin
        mlen[8 * rx_idx[0] +: 8] <= rx_data; // The field starts at an even offset.
      end
      if (in_body) begin
        cfg_in[body_k] <= rx_data;
      end
    end
  end

  // Count of bytes really written for the current request.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_cnt <= 16'h0000;
    end else if (state == NBCH_PROC) begin
      wr_cnt <= 16'h0000;
    end else if (mem_we) begin
      wr_cnt <= wr_cnt + 16'h0001;
    end
  end

  // Configuration store; it changes only on an accepted configure request.
  // A failed request still records its completion code so the reply agrees.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `NBCH_CFG_LEN; i++) begin
        cfg_q[i] <= (i == `NBCH_CFG_MODE) ? `NBCH_MODE_NET : 8'h00;
      end
    end else if (cf_go) begin
      for (int i = 0; i < `NBCH_CFG_LEN; i++) begin
        if (st_cf == `NBCH_ST_OK && !(hosts_none && i >= `NBCH_CFG_HOSTQ)) begin
          cfg_q[i] <= cfg_in[i];
        end
      end
      cfg_q[`NBCH_CFG_COMP] <= st_cf;
      cfg_q[`NBCH_CFG_MODE] <= `NBCH_MODE_NET;
    end
  end

  // Reply descriptor and execution hand-off, settled in the decision cycle.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rsp_st <= 8'h00;
      rsp_cnt <= 16'h0000;
      rsp_len <= 9'h000;
      exec_go <= 1'b0;
      exec_pc <= 32'h0000_0000;
      boot_done <= 1'b0;
    end else begin
      exec_go <= ex_go;
      if (in_proc) begin
        rsp_st <= next_st;
        rsp_cnt <= next_cnt;
        rsp_len <= next_len;
      end
      if (ex_go) begin
        exec_pc <= ex_addr;
        boot_done <= 1'b1;
      end
    end
  end

  // Reply shifter: one byte is staged in a register before it is offered.
  // Read data cost one extra cycle because the memory port is registered.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_idx <= 9'h000;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
    end else begin
      if (state == NBCH_PROC) begin
        tx_idx <= 9'h000;
      end else if (state == NBCH_SEND && tx_ready) begin
        tx_idx <= tx_idx + 9'h001;
      end
      if (state == NBCH_LOAD) begin
        tx_data <= rep_byte(tx_idx);
        tx_last <= last_byte;
      end else if (state == NBCH_FETCH) begin
        tx_data <= mem_rdata;
      end
    end
  end

  nbch_ram #(.AW(RAM_AW)) u_ram (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(rx_data),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // Checks on the sequencer and reply contents.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  property p_halt_silent;
    boot_done |=> !exec_go && !mem_we;
  endproperty
  a_halt_silent: assert property (p_halt_silent) else $error("Activity after execute.");
  property p_sess_drop;
    (state == NBCH_PROC && !sess_ok) |=> state == NBCH_RX;
  endproperty
  a_sess_drop: assert property (p_sess_drop) else $error("Foreign session answered.");
  property p_code_echo;
    (state == NBCH_LOAD && tx_idx == `NBCH_OFF_REQ) |=> tx_data == reqc;
  endproperty
  a_code_echo: assert property (p_code_echo) else $error("Request code not echoed.");
  property p_exec_pc;
    $rose(exec_go) |-> exec_pc == $past(ex_addr) && boot_done;
  endproperty
  a_exec_pc: assert property (p_exec_pc) else $error("Start address not loaded.");
  property p_mode_two;
    (state == NBCH_LOAD && is_cf && tx_idx == `NBCH_OFF_BODY + `NBCH_CFG_MODE)
      |=> tx_data == `NBCH_MODE_NET;
  endproperty
  a_mode_two: assert property (p_mode_two) else $error("Mode field not 2.");
  property p_cf_code;
    (state == NBCH_LOAD && is_cf && tx_idx == `NBCH_OFF_RC)
      |=> tx_data == cfg_q[`NBCH_CFG_COMP];
  endproperty
  a_cf_code: assert property (p_cf_code) else $error("Reply code differs from block.");
  property p_wr_safe;
    mem_we |-> rw_lin >= 20'(RESV_TOP) && is_wr && wr_cnt < len;
  endproperty
  a_wr_safe: assert property (p_wr_safe) else $error("Write into reserved memory.");
  property p_rd_count;
    (state == NBCH_LOAD && is_rd && tx_idx == `NBCH_OFF_BODY) |=> tx_data == rsp_cnt[7:0];
  endproperty
  a_rd_count: assert property (p_rd_count) else $error("Read count not reported.");
  property p_bad_code;
    (in_proc && reqc > `NBCH_CODE_CF) |=> rsp_st == `NBCH_ST_INV && rsp_len == `NBCH_OFF_BODY;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("Unknown code not refused.");
  c_exec: cover property ($rose(exec_go));
  c_cfg: cover property (cf_go && st_cf == `NBCH_ST_OK);
  c_read: cover property (state == NBCH_FETCH ##1 state == NBCH_SEND && tx_ready);
endmodule

/* tb/nbch_srv.sv */
// Boot server model: feeds request packets and collects reply bytes.
`timescale 1ns/1ps
module nbch_srv import nbch_pkg::*; (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Request stream toward the device.
  output logic rx_valid,
  output nbch_byte_t rx_data,
  output logic rx_last,
  input wire logic rx_ready,
  // Reply stream from the device.
  input wire logic tx_valid,
  input wire nbch_byte_t tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  // Idle levels at time zero; the device takes nothing while valid is low.
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b0;
  end

  // Sends one packet; a byte holds until ready is seen high before the edge that takes it.
  // With gaps on, the data line toggles while valid is low so stale bytes never look valid.
  task automatic send_pkt(input nbch_byte_t q[$], input bit gap);
    wait (arst_n === 1'b1);
    for (int i = 0; i < q.size(); i++) begin
      @(negedge clk_sys);
      if (gap && i % 5 == 4) begin
        rx_valid = 1'b0;
        rx_data = ~rx_data;
        @(negedge clk_sys);
      end
      rx_valid = 1'b1;
      rx_data = q[i];
      rx_last = (i == q.size() - 1);
      while (rx_ready !== 1'b1) @(negedge clk_sys);
    end
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = ~rx_data;
  endtask

  // Collects one reply; slow mode accepts only every third cycle to stall the device.
  task automatic recv(output nbch_byte_t q[$], input bit slow, input int limit);
    int n;
    q = {};
    n = 0;
    while (n < limit) begin
      @(negedge clk_sys);
      n++;
      tx_ready = !slow || (n % 3 == 0);
      if (tx_valid === 1'b1 && tx_ready) begin
        q.push_back(tx_data);
        if (tx_last === 1'b1) break;
      end
    end
    @(negedge clk_sys);
    tx_ready = 1'b0;
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the boot command handler.
`timescale 1ns/1ps
module testbench import nbch_pkg::*;;
  logic clk_sys;
  logic arst_n;
  logic sess_valid;
  logic [95:0] sess_id;
  logic [95:0] sid;
  logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, exec_go, boot_done;
  nbch_byte_t rx_data;
  nbch_byte_t tx_data;
  logic [31:0] exec_pc;
  logic [31:0] seed = 32'd14607;
  logic [31:0] adr;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  int n_go = 0;
  int n, sent, lin;
  nbch_byte_t req[$];
  nbch_byte_t rep[$];
  nbch_byte_t mem [0:1023];

  // Device with a small user memory so address limits are cheap to reach.
  nbch_top #(.RAM_AW(10), .RAM_BYTES(1024), .RESV_TOP(256)) i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .sess_valid(sess_valid), .sess_id(sess_id),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .exec_go(exec_go), .exec_pc(exec_pc), .boot_done(boot_done));

  // Boot server on the far side.
  nbch_srv i_srv (
    .clk_sys(clk_sys), .arst_n(arst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready));

  // Free-running 200 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Counts start pulses and cuts a hang short.
  // The falling edge keeps the count clear of the edges that move the pulse.
  always @(negedge clk_sys) begin
    if (exec_go === 1'b1) n_go = n_go + 1;
    cycles = cycles + 1;
    if (cycles == 80000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Segment plus offset form of a linear address; k moves weight from segment to offset.
  function automatic logic [31:0] sgo(input int lin, input int k);
    return {16'(lin / 16 - k), 16'(lin % 16 + 16 * k)};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Appends the low bytes of a value, low byte first.
  task automatic put(input logic [31:0] v, input int nb);
    for (int i = 0; i < nb; i++) req.push_back(v[8 * i +: 8]);
  endtask

  task automatic hdr(input nbch_byte_t code, input logic [15:0] ml);
    req = {};
    put(rnd(), 2);
    for (int k = 0; k < 12; k++) req.push_back(sid[95 - 8 * k -: 8]);
    put(rnd(), 4);
    put({24'h0, code}, 1);
    put(32'h0, 1);
    put({16'h0, ml}, 2);
  endtask

  task automatic rw(input nbch_byte_t code, input int len, input logic [31:0] a,
                    input logic [15:0] ml);
    hdr(code, ml);
    put(32'(len), 2);
    put(32'h0, 4);
    put(a, 4);
  endtask

  task automatic xact(input bit slow, input int lim);
    i_srv.send_pkt(req, slow);
    i_srv.recv(rep, slow, lim);
  endtask

  // Common reply fields: size, identifier echo, code echo, status and message length.
  task automatic chk_rep(input nbch_byte_t code, input nbch_byte_t st, input int total);
    chk("size", 32'(rep.size()), 32'(total));
    if (rep.size() >= 22) begin
      for (int i = 0; i < 18; i++) chk("id", rep[i], req[i]);
      chk("code", rep[18], code);
      chk("status", rep[19], st);
      chk("mlen", {16'h0, rep[21], rep[20]}, 32'(total - 22));
    end
  endtask

  // Main sequence: refusals, configure, write and read traffic, errors, execute.
  initial begin
    arst_n = 1'b0;
    sess_valid = 1'b0;
    sess_id = {rnd(), rnd(), rnd()};
    sid = sess_id;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    rw(8'h01, 4, sgo(256, 0), 16'h000a);
    xact(0, 60);
    chk("drop", 32'(rep.size()), 0);
    sess_valid = 1'b1;
    sid = sess_id ^ (96'h1 << (8 * (rnd() % 12)));
    rw(8'h01, 4, sgo(256, 0), 16'h000a);
    xact(0, 60);
    chk("drop", 32'(rep.size()), 0);
    sid = sess_id;
    hdr(8'h03, 16'h0050);
    for (int i = 0; i < 80; i++) req.push_back(i == 3 ? 8'h02 : (i < 5 ? 8'h00 : 8'(rnd())));
    xact(1, 2000);
    chk_rep(8'h03, 8'h00, 102);
    chk("comp", rep[24], 8'h00);
    chk("mode", rep[25], 8'h02);
    for (int i = 5; i < 80; i++) chk("hostq", rep[22 + i], 8'h00);
    req[25] = 8'h03;
    xact(0, 2000);
    chk("status", rep[19], 8'ha1);
    chk("comp", rep[24], 8'ha1);
    chk("mode", rep[25], 8'h02);
    req[25] = 8'h02;
    req[26] = 8'h01;
    xact(1, 2000);
    chk_rep(8'h03, 8'h00, 102);
    for (int i = 0; i < 80; i++) chk("block", rep[22 + i], req[22 + i]);
    for (int it = 0; it < 6; it++) begin
      n = (it == 0) ? 462 : 8 + rnd() % 40;
      sent = (it == 1) ? n - 4 : n;
      lin = 256 + rnd() % (769 - n);
      adr = sgo(lin, rnd() % 16);
      rw(8'h00, n, adr, 16'(10 + sent));
      for (int i = 0; i < sent; i++) begin
        mem[lin + i] = 8'(rnd());
        req.push_back(mem[lin + i]);
      end
      xact(it[0], 3000);
      chk_rep(8'h00, 8'h00, 32);
      chk("wlen", {16'h0, rep[23], rep[22]}, 32'(sent));
      chk("wadr", {rep[31], rep[30], rep[29], rep[28]}, adr);
      rw(8'h01, sent, adr, 16'h000a);
      xact(~it[0], 3000);
      chk_rep(8'h01, 8'h00, 32 + sent);
      chk("rlen", {16'h0, rep[23], rep[22]}, 32'(sent));
      chk("radr", {rep[31], rep[30], rep[29], rep[28]}, adr);
      for (int i = 0; i < sent; i++) chk("data", rep[32 + i], mem[lin + i]);
    end
    rw(8'h00, 4, sgo(16, 0), 16'h000e);
    put(rnd(), 4);
    xact(0, 2000);
    chk_rep(8'h00, 8'ha3, 32);
    chk("wlen", {16'h0, rep[23], rep[22]}, 0);
    rw(8'h01, 8, sgo(1020, 3), 16'h000a);
    xact(0, 2000);
    chk_rep(8'h01, 8'ha3, 32);
    rw(8'h01, 463, sgo(256, 0), 16'h000a);
    xact(0, 2000);
    chk_rep(8'h01, 8'ha1, 32);
    rw(8'h01, 4, sgo(256, 0), 16'h000c);
    xact(0, 2000);
    chk_rep(8'h01, 8'ha1, 32);
    hdr(8'h07, 16'h0000);
    xact(0, 2000);
    chk_rep(8'h07, 8'ha1, 22);
    hdr(8'h02, 16'h0004);
    put(sgo(32, 1), 4);
    xact(0, 2000);
    chk_rep(8'h02, 8'ha2, 26);
    chk("go", 32'(n_go), 0);
    adr = sgo(300, 5);
    hdr(8'h02, 16'h0004);
    put(adr, 4);
    xact(1, 2000);
    chk_rep(8'h02, 8'h00, 26);
    chk("pcecho", {rep[25], rep[24], rep[23], rep[22]}, adr);
    chk("go", 32'(n_go), 1);
    chk("pc", exec_pc, adr);
    chk("done", {31'h0, boot_done}, 1);
    rw(8'h01, 4, sgo(256, 0), 16'h000a);
    xact(0, 60);
    chk("drop", 32'(rep.size()), 0);
    stop_test();
  end
endmodule
